// file: rtl/rci_pkg.sv
/*
  Constants, register map and event kinds for the reset-cause and
  register-initialisation block.
  Assumes one 200 MHz core clock and event strobes already synchronous to it.
*/
package rci_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [4:0] RCI_OFS_CTL   = 5'h00;
  localparam logic [4:0] RCI_OFS_STK   = 5'h04;
  localparam logic [4:0] RCI_OFS_CFG   = 5'h08;
  localparam logic [4:0] RCI_OFS_PC    = 5'h0c;
  localparam logic [4:0] RCI_OFS_TOS   = 5'h10;
  localparam logic [4:0] RCI_OFS_PCLAT = 5'h14;
  localparam logic [4:0] RCI_OFS_TBL   = 5'h18;
  localparam logic [4:0] RCI_OFS_SCR   = 5'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int RCI_CTL_SWBO  = 6;
  localparam int RCI_CTL_INSTR = 4;
  localparam int RCI_CTL_TMO   = 3;
  localparam int RCI_CTL_PWDN  = 2;
  localparam int RCI_CTL_PWON  = 1;
  localparam int RCI_CTL_BROWN = 0;
  localparam int RCI_STK_FUL   = 7;
  localparam int RCI_STK_UNF   = 6;
  localparam int RCI_CFG_STVR  = 0;
  localparam int RCI_CFG_BOCFG = 1;

  ////////////////////////////////////////////////////////////////////////////
  // widths and values
  localparam int          RCI_PC_W     = 21;
  localparam int          RCI_TBL_W    = 22;
  localparam int          RCI_PCLAT_W  = 13;
  localparam int          RCI_PTR_W    = 5;
  localparam logic [1:0]  RCI_BOCFG_SW  = 2'h1;
  localparam logic [1:0]  RCI_BOCFG_RST = 2'h0;
  localparam logic        RCI_SWBO_RST  = 1'h1;
  localparam logic [7:0]  RCI_CTL_RST   = 8'h5c;
  localparam logic [20:0] RCI_PC_RST   = 21'h000000;
  localparam logic [20:0] RCI_PC_STEP  = 21'h000002;
  localparam logic [20:0] RCI_VEC_HI   = 21'h000008;
  localparam logic [20:0] RCI_VEC_LO   = 21'h000018;
  localparam logic [4:0]  RCI_PTR_RST  = 5'h00;
  localparam logic [4:0]  RCI_PTR_STEP = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // power modes and arbitrated events
  typedef enum logic [1:0] {
    RCI_PM_FULL,
    RCI_PM_RUN,
    RCI_PM_IDLE,
    RCI_PM_SLEEP
  } rci_pm_t;

  typedef enum logic [3:0] {
    RCI_EV_NONE,
    RCI_EV_POR,
    RCI_EV_BOR,
    RCI_EV_RST_INSTR,
    RCI_EV_XCLR_FULL,
    RCI_EV_XCLR_RUN,
    RCI_EV_XCLR_IDLE,
    RCI_EV_WDT_RESET,
    RCI_EV_STK_FULL,
    RCI_EV_STK_UNF,
    RCI_EV_STK_FULL_ERR,
    RCI_EV_STK_UNF_ERR,
    RCI_EV_WDT_WAKE,
    RCI_EV_INT_WAKE
  } rci_event_t;

endpackage

// file: rtl/rci_event_arb.sv
/*
  Priority arbiter: turns the raw reset and wake strobes into one
  registered event kind per cycle.
  Assumes strobes are one-cycle pulses synchronous to ref_clk_in.
*/
`timescale 1ns/1ps
module rci_event_arb (
  input  wire logic                ref_clk_in,
  input  wire logic                rst_in,
  input  wire logic                por_evt_in,
  input  wire logic                bor_evt_in,
  input  wire logic                reset_instr_in,
  input  wire logic                ext_clear_evt_in,
  input  wire logic                wdt_timeout_in,
  input  wire logic                stack_full_evt_in,
  input  wire logic                stack_unf_evt_in,
  input  wire logic                int_wake_in,
  input  wire logic                stack_error_reset_enable_in,
  input  wire rci_pkg::rci_pm_t    pm_mode_in,
  output rci_pkg::rci_event_t      evt_out
);

  rci_pkg::rci_event_t evt_r;
  rci_pkg::rci_event_t evt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // fixed priority, only the winner's flag updates are applied
  always_comb begin
    evt_nxt = rci_pkg::RCI_EV_NONE;
    if (por_evt_in) begin
      evt_nxt = rci_pkg::RCI_EV_POR;
    end else if (bor_evt_in) begin
      evt_nxt = rci_pkg::RCI_EV_BOR;
    end else if (reset_instr_in) begin
      evt_nxt = rci_pkg::RCI_EV_RST_INSTR;
    end else if (ext_clear_evt_in) begin
      case (pm_mode_in)
        rci_pkg::RCI_PM_FULL:  evt_nxt = rci_pkg::RCI_EV_XCLR_FULL;
        rci_pkg::RCI_PM_RUN:   evt_nxt = rci_pkg::RCI_EV_XCLR_RUN;
        default:               evt_nxt = rci_pkg::RCI_EV_XCLR_IDLE;
      endcase
    end else if (wdt_timeout_in) begin
      // idle and sleep turn a timeout into a wake-up instead of a reset
      if (pm_mode_in == rci_pkg::RCI_PM_IDLE || pm_mode_in == rci_pkg::RCI_PM_SLEEP) begin
        evt_nxt = rci_pkg::RCI_EV_WDT_WAKE;
      end else begin
        evt_nxt = rci_pkg::RCI_EV_WDT_RESET;
      end
    end else if (stack_full_evt_in) begin
      evt_nxt = stack_error_reset_enable_in ? rci_pkg::RCI_EV_STK_FULL
                                         : rci_pkg::RCI_EV_STK_FULL_ERR;
    end else if (stack_unf_evt_in) begin
      evt_nxt = stack_error_reset_enable_in ? rci_pkg::RCI_EV_STK_UNF
                                         : rci_pkg::RCI_EV_STK_UNF_ERR;
    end else if (int_wake_in && pm_mode_in != rci_pkg::RCI_PM_FULL) begin
      evt_nxt = rci_pkg::RCI_EV_INT_WAKE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      evt_r <= rci_pkg::RCI_EV_NONE;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  assign evt_out = evt_r;

endmodule

// file: rtl/rci_reset_init.sv
/*
  Reset-cause flags, stack flags, program counter selection and the
  reset-state registers, reached over an Avalon-MM slave with waitrequest.
  Assumes the core drives pc_load_in while running and sends one-cycle
  event strobes; every answer on the bus comes one cycle after the request.
*/
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module rci_reset_init (
  input  wire logic                ref_clk_in,
  input  wire logic                rst_in,
  input  wire logic                por_evt_in,
  input  wire logic                bor_evt_in,
  input  wire logic                reset_instr_in,
  input  wire logic                ext_clear_evt_in,
  input  wire logic                wdt_timeout_in,
  input  wire logic                stack_full_evt_in,
  input  wire logic                stack_unf_evt_in,
  input  wire logic                int_wake_in,
  input  wire logic                high_priority_global_int_enable_in,
  input  wire logic                low_priority_global_int_enable_in,
  input  wire rci_pkg::rci_pm_t    pm_mode_in,
  input  wire logic                pc_load_in,
  input  wire logic [20:0]         pc_value_in,
  input  wire logic [4:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic [31:0]              avs_readdata_out,
  output logic                     avs_waitrequest_out,
  output logic [20:0]              pc_out,
  output logic                     core_reset_out,
  output logic                     wake_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  rci_pkg::rci_event_t  evt;
  logic [7:0]           ctl_r,    ctl_nxt;
  logic [7:0]           stk_r,    stk_nxt;
  logic [2:0]           cfg_r,    cfg_nxt;
  logic [20:0]          pc_r,     pc_nxt;
  logic [20:0]          tos_r,    tos_nxt;
  logic [12:0]          pclat_r,  pclat_nxt;
  logic [21:0]          tbl_r,    tbl_nxt;
  logic [31:0]          scr_r,    scr_nxt;
  logic                 wait_r,   wait_nxt;
  logic [31:0]          rdata_r,  rdata_nxt;
  logic                 crst_r,   crst_nxt;
  logic                 wake_r,   wake_nxt;
  logic                 wr_go;
  logic                 rd_cap;
  logic                 sw_bo_mode;
  logic [31:0]          rd_word;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  rci_event_arb u_arb (
    .ref_clk_in                  (ref_clk_in),
    .rst_in                      (rst_in),
    .por_evt_in                  (por_evt_in),
    .bor_evt_in                  (bor_evt_in),
    .reset_instr_in              (reset_instr_in),
    .ext_clear_evt_in            (ext_clear_evt_in),
    .wdt_timeout_in              (wdt_timeout_in),
    .stack_full_evt_in           (stack_full_evt_in),
    .stack_unf_evt_in            (stack_unf_evt_in),
    .int_wake_in                 (int_wake_in),
    .stack_error_reset_enable_in (cfg_r[rci_pkg::RCI_CFG_STVR]),
    .pm_mode_in                  (pm_mode_in),
    .evt_out                     (evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: a request is seen with waitrequest high and answered next edge
  assign wr_go    = avs_write_in && !wait_r;
  assign rd_cap   = avs_read_in && wait_r;
  assign sw_bo_mode = (cfg_r[rci_pkg::RCI_CFG_BOCFG +: 2] == rci_pkg::RCI_BOCFG_SW);

  always_comb begin
    rd_word = 32'h00000000;
    case (avs_address_in)
      rci_pkg::RCI_OFS_CTL: begin
        rd_word[7:0] = ctl_r;
        rd_word[rci_pkg::RCI_CTL_SWBO] = ctl_r[rci_pkg::RCI_CTL_SWBO] & sw_bo_mode;
      end
      rci_pkg::RCI_OFS_STK:   rd_word[7:0]  = stk_r;
      rci_pkg::RCI_OFS_CFG:   rd_word[2:0]  = cfg_r;
      rci_pkg::RCI_OFS_PC:    rd_word[20:0] = pc_r;
      rci_pkg::RCI_OFS_TOS:   rd_word[20:0] = tos_r;
      rci_pkg::RCI_OFS_PCLAT: rd_word[12:0] = pclat_r;
      rci_pkg::RCI_OFS_TBL:   rd_word[21:0] = tbl_r;
      rci_pkg::RCI_OFS_SCR:   rd_word       = scr_r;
      default:                rd_word       = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: software write first, then the event, so hardware wins
  always_comb begin
    logic [31:0] m;
    m         = 32'h00000000;
    ctl_nxt   = ctl_r;
    stk_nxt   = stk_r;
    cfg_nxt   = cfg_r;
    pc_nxt    = pc_r;
    tos_nxt   = tos_r;
    pclat_nxt = pclat_r;
    tbl_nxt   = tbl_r;
    scr_nxt   = scr_r;
    crst_nxt  = 1'b0;
    wake_nxt  = 1'b0;
    wait_nxt  = !((avs_read_in || avs_write_in) && wait_r);
    rdata_nxt = rd_cap ? rd_word : rdata_r;

    if (wr_go) begin
      case (avs_address_in)
        rci_pkg::RCI_OFS_CTL: begin
          m = be_merge({24'h000000, ctl_r}, avs_writedata_in, avs_byteenable_in);
          ctl_nxt = {1'b0, ctl_r[6], 1'b0, m[4:0]};
          if (sw_bo_mode) begin
            ctl_nxt[rci_pkg::RCI_CTL_SWBO] = m[rci_pkg::RCI_CTL_SWBO];
          end
        end
        rci_pkg::RCI_OFS_STK: begin
          m = be_merge({24'h000000, stk_r}, avs_writedata_in, avs_byteenable_in);
          stk_nxt = {m[7:6], 1'b0, m[4:0]};
        end
        rci_pkg::RCI_OFS_CFG: begin
          m = be_merge({29'h00000000, cfg_r}, avs_writedata_in, avs_byteenable_in);
          cfg_nxt = m[2:0];
        end
        rci_pkg::RCI_OFS_PCLAT: begin
          m = be_merge({19'h00000, pclat_r}, avs_writedata_in, avs_byteenable_in);
          pclat_nxt = m[12:0];
        end
        rci_pkg::RCI_OFS_TBL: begin
          m = be_merge({10'h000, tbl_r}, avs_writedata_in, avs_byteenable_in);
          tbl_nxt = m[21:0];
        end
        rci_pkg::RCI_OFS_SCR: scr_nxt = be_merge(scr_r, avs_writedata_in, avs_byteenable_in);
        default: ;
      endcase
    end

    if (pc_load_in) begin
      pc_nxt = pc_value_in;
    end

    case (evt)
      rci_pkg::RCI_EV_POR: begin
        ctl_nxt[rci_pkg::RCI_CTL_INSTR] = 1'b1;
        ctl_nxt[rci_pkg::RCI_CTL_TMO]   = 1'b1;
        ctl_nxt[rci_pkg::RCI_CTL_PWDN]  = 1'b1;
        ctl_nxt[rci_pkg::RCI_CTL_PWON]  = 1'b0;
        ctl_nxt[rci_pkg::RCI_CTL_BROWN] = 1'b0;
        ctl_nxt[rci_pkg::RCI_CTL_SWBO]  = rci_pkg::RCI_SWBO_RST;
        stk_nxt   = {2'b00, 1'b0, rci_pkg::RCI_PTR_RST};
        cfg_nxt   = {rci_pkg::RCI_BOCFG_RST, 1'b0};
        // the scratch word is left alone: power-on gives it no defined value
      end
      rci_pkg::RCI_EV_BOR: begin
        ctl_nxt[rci_pkg::RCI_CTL_INSTR] = 1'b1;
        ctl_nxt[rci_pkg::RCI_CTL_TMO]   = 1'b1;
        ctl_nxt[rci_pkg::RCI_CTL_PWDN]  = 1'b1;
        ctl_nxt[rci_pkg::RCI_CTL_BROWN] = 1'b0;
      end
      rci_pkg::RCI_EV_RST_INSTR: ctl_nxt[rci_pkg::RCI_CTL_INSTR] = 1'b0;
      rci_pkg::RCI_EV_XCLR_RUN:  ctl_nxt[rci_pkg::RCI_CTL_TMO] = 1'b1;
      rci_pkg::RCI_EV_XCLR_IDLE: begin
        ctl_nxt[rci_pkg::RCI_CTL_TMO]  = 1'b1;
        ctl_nxt[rci_pkg::RCI_CTL_PWDN] = 1'b0;
      end
      rci_pkg::RCI_EV_XCLR_FULL: ;
      rci_pkg::RCI_EV_WDT_RESET: ctl_nxt[rci_pkg::RCI_CTL_TMO] = 1'b0;
      rci_pkg::RCI_EV_STK_FULL:  stk_nxt[rci_pkg::RCI_STK_FUL] = 1'b1;
      rci_pkg::RCI_EV_STK_UNF:   stk_nxt[rci_pkg::RCI_STK_UNF] = 1'b1;
      rci_pkg::RCI_EV_STK_FULL_ERR: stk_nxt[rci_pkg::RCI_STK_FUL] = 1'b1;
      rci_pkg::RCI_EV_STK_UNF_ERR:  stk_nxt[rci_pkg::RCI_STK_UNF] = 1'b1;
      rci_pkg::RCI_EV_WDT_WAKE: begin
        ctl_nxt[rci_pkg::RCI_CTL_TMO]  = 1'b0;
        ctl_nxt[rci_pkg::RCI_CTL_PWDN] = 1'b0;
        pc_nxt   = pc_r + rci_pkg::RCI_PC_STEP;
        wake_nxt = 1'b1;
      end
      rci_pkg::RCI_EV_INT_WAKE: begin
        ctl_nxt[rci_pkg::RCI_CTL_PWDN] = 1'b0;
        pc_nxt   = pc_r + rci_pkg::RCI_PC_STEP;
        wake_nxt = 1'b1;
        // vectored wake pushes the resume address onto the hardware stack
        if (high_priority_global_int_enable_in || low_priority_global_int_enable_in) begin
          tos_nxt = pc_r + rci_pkg::RCI_PC_STEP;
          stk_nxt[4:0] = stk_r[4:0] + rci_pkg::RCI_PTR_STEP;
          pc_nxt = high_priority_global_int_enable_in ? rci_pkg::RCI_VEC_HI
                                                      : rci_pkg::RCI_VEC_LO;
        end
      end
      default: ;
    endcase

    // every true reset forces the reset-state registers to their common values
    case (evt)
      rci_pkg::RCI_EV_POR, rci_pkg::RCI_EV_BOR, rci_pkg::RCI_EV_RST_INSTR,
      rci_pkg::RCI_EV_XCLR_FULL, rci_pkg::RCI_EV_XCLR_RUN, rci_pkg::RCI_EV_XCLR_IDLE,
      rci_pkg::RCI_EV_WDT_RESET, rci_pkg::RCI_EV_STK_FULL, rci_pkg::RCI_EV_STK_UNF: begin
        pc_nxt       = rci_pkg::RCI_PC_RST;
        tos_nxt      = 21'h000000;
        pclat_nxt    = 13'h0000;
        tbl_nxt      = 22'h000000;
        stk_nxt[4:0] = rci_pkg::RCI_PTR_RST;
        crst_nxt     = 1'b1;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; rst_in acts as a power-on of the block
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctl_r   <= rci_pkg::RCI_CTL_RST;
      stk_r   <= 8'h00;
      cfg_r   <= 3'h0;
      pc_r    <= rci_pkg::RCI_PC_RST;
      tos_r   <= 21'h000000;
      pclat_r <= 13'h0000;
      tbl_r   <= 22'h000000;
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
      crst_r  <= 1'b0;
      wake_r  <= 1'b0;
    end else begin
      ctl_r   <= ctl_nxt;
      stk_r   <= stk_nxt;
      cfg_r   <= cfg_nxt;
      pc_r    <= pc_nxt;
      tos_r   <= tos_nxt;
      pclat_r <= pclat_nxt;
      tbl_r   <= tbl_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      crst_r  <= crst_nxt;
      wake_r  <= wake_nxt;
    end
  end

  // data word with no reset state: it must survive every reset
  always_ff @(posedge ref_clk_in) begin
    scr_r <= scr_nxt;
  end

  assign avs_readdata_out    = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign pc_out              = pc_r;
  assign core_reset_out      = crst_r;
  assign wake_out            = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  por_flags_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt == rci_pkg::RCI_EV_POR) |=> (ctl_r[4:0] == 5'h1c) && (stk_r == 8'h00)
      && (pc_r == rci_pkg::RCI_PC_RST) && core_reset_out)
    else $error("power-on flags or pc wrong");

  bor_flags_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt == rci_pkg::RCI_EV_BOR && !wr_go) |=> (ctl_r[4:2] == 3'h7)
      && !ctl_r[0] && (ctl_r[1] == $past(ctl_r[1])) && (stk_r[7:6] == $past(stk_r[7:6])))
    else $error("brown-out flags wrong");

  xclr_idle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt == rci_pkg::RCI_EV_XCLR_IDLE && !wr_go) |=> ctl_r[3] && !ctl_r[2]
      && (ctl_r[4] == $past(ctl_r[4])) && (pc_r == rci_pkg::RCI_PC_RST))
    else $error("clear in idle flags wrong");

  wdt_reset_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt == rci_pkg::RCI_EV_WDT_RESET && !wr_go) |=> !ctl_r[3]
      && (ctl_r[2] == $past(ctl_r[2])) && core_reset_out)
    else $error("watchdog reset flags wrong");

  unf_noreset_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt == rci_pkg::RCI_EV_STK_UNF_ERR) |=> stk_r[6] && !core_reset_out)
    else $error("underflow error reset the core");

  wdt_wake_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt == rci_pkg::RCI_EV_WDT_WAKE && !pc_load_in) |=>
      (pc_r == $past(pc_r) + rci_pkg::RCI_PC_STEP) && !ctl_r[3] && !ctl_r[2] && wake_out)
    else $error("watchdog wake pc or flags wrong");

  int_vector_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt == rci_pkg::RCI_EV_INT_WAKE && high_priority_global_int_enable_in) |=>
      (pc_r == rci_pkg::RCI_VEC_HI) && (tos_r == $past(pc_r) + rci_pkg::RCI_PC_STEP))
    else $error("interrupt wake vector wrong");

  scratch_keep_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (evt != rci_pkg::RCI_EV_NONE && !wr_go) |=> $stable(scr_r))
    else $error("scratch word changed on reset");

  sbor_read_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (rd_cap && avs_address_in == rci_pkg::RCI_OFS_CTL && !sw_bo_mode) |=> !avs_readdata_out[6])
    else $error("software brown-out enable visible outside software mode");

  bus_answer_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ((avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out
      ##1 avs_waitrequest_out)
    else $error("bus answer not one cycle after request");

endmodule

// file: tb/testbench.sv
/*
  Self-checking bench for rci_reset_init: bus tasks, event strobes, flag checks.
  Assumes the one-cycle bus answer and two-edge event latency of the block.
*/
`timescale 1ns/1ps
module testbench;
  logic             ref_clk_in   = 1'b0;
  logic             rst_in       = 1'b1;
  logic [7:0]       ev_r         = 8'h00;
  logic             hi_en_r      = 1'b0;
  logic             lo_en_r      = 1'b0;
  rci_pkg::rci_pm_t pm_r         = rci_pkg::RCI_PM_FULL;
  logic             pc_ld_r      = 1'b0;
  logic [4:0]       adr_r        = 5'h00;
  logic             rd_r         = 1'b0;
  logic             wr_r         = 1'b0;
  logic [31:0]      wdat_r       = 32'h0;
  logic [3:0]       be_r         = 4'hf;
  logic [31:0]      rdat;
  logic             wait_w;
  logic             core_rst;
  logic             wake;
  logic [20:0]      pc;
  int               n_errors     = 0;
  int               total_checks = 0;
  int               cyc          = 0;

  always #2.5 ref_clk_in = ~ref_clk_in;

  // strobe vector order: por, bor, instr, ext clear, watchdog, full, underflow, int wake
  rci_reset_init u_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .por_evt_in(ev_r[7]), .bor_evt_in(ev_r[6]),
    .reset_instr_in(ev_r[5]), .ext_clear_evt_in(ev_r[4]), .wdt_timeout_in(ev_r[3]),
    .stack_full_evt_in(ev_r[2]), .stack_unf_evt_in(ev_r[1]), .int_wake_in(ev_r[0]),
    .high_priority_global_int_enable_in(hi_en_r), .low_priority_global_int_enable_in(lo_en_r),
    .pm_mode_in(pm_r), .pc_load_in(pc_ld_r), .pc_value_in(21'h000100),
    .avs_address_in(adr_r), .avs_read_in(rd_r), .avs_write_in(wr_r),
    .avs_writedata_in(wdat_r), .avs_byteenable_in(be_r), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_w), .pc_out(pc), .core_reset_out(core_rst), .wake_out(wake));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the leading edge keeps a new request from landing in the release time step
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge ref_clk_in);
    adr_r <= a;
    wdat_r <= d;
    be_r <= b;
    wr_r <= 1'b1;
    do @(posedge ref_clk_in); while (wait_w !== 1'b0);
    wr_r <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge ref_clk_in);
    adr_r <= a;
    rd_r <= 1'b1;
    do @(posedge ref_clk_in); while (wait_w !== 1'b0);
    chk(rdat, e);
    rd_r <= 1'b0;
  endtask

  task automatic fire(input logic [7:0] ev, input logic [1:0] pm, input logic [7:0] pre,
                      input logic [7:0] e, input logic [20:0] epc, input logic er,
                      input logic ew);
    wr(5'h00, {24'h0, pre}, 4'hf);
    @(posedge ref_clk_in);
    pm_r <= rci_pkg::rci_pm_t'(pm);
    pc_ld_r <= 1'b1;
    @(posedge ref_clk_in);
    pc_ld_r <= 1'b0;
    ev_r <= ev;
    @(posedge ref_clk_in);
    ev_r <= 8'h00;
    @(posedge ref_clk_in);
    #1;
    chk({31'h0, core_rst}, {31'h0, er});
    chk({31'h0, wake}, {31'h0, ew});
    chk({11'h0, pc}, {11'h0, epc});
    rd(5'h00, {24'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(5'h00, 32'h0000001c);
    rd(5'h04, 32'h0);
    rd(5'h08, 32'h0);
    wr(5'h1c, 32'h11223344, 4'hf);
    wr(5'h1c, 32'haabbccdd, 4'h2);
    rd(5'h1c, 32'h1122cc44);
    wr(5'h0c, 32'h00001234, 4'hf);
    rd(5'h0c, 32'h0);
    rd(5'h02, 32'h0);
  endtask

  task automatic t_flags();
    wr(5'h14, 32'h00001abc, 4'hf);
    wr(5'h18, 32'h003fffff, 4'hf);
    fire(8'h20, 2'h0, 8'h1f, 8'h0f, 21'h0, 1'b1, 1'b0);
    rd(5'h14, 32'h0);
    rd(5'h18, 32'h0);
    rd(5'h1c, 32'h1122cc44);
    fire(8'h10, 2'h0, 8'h17, 8'h17, 21'h0, 1'b1, 1'b0);
    fire(8'h10, 2'h1, 8'h17, 8'h1f, 21'h0, 1'b1, 1'b0);
    fire(8'h10, 2'h2, 8'h17, 8'h1b, 21'h0, 1'b1, 1'b0);
    fire(8'h10, 2'h3, 8'h17, 8'h1b, 21'h0, 1'b1, 1'b0);
    fire(8'h08, 2'h0, 8'h1f, 8'h17, 21'h0, 1'b1, 1'b0);
    fire(8'h08, 2'h1, 8'h1f, 8'h17, 21'h0, 1'b1, 1'b0);
    fire(8'h40, 2'h0, 8'h02, 8'h1e, 21'h0, 1'b1, 1'b0);
    fire(8'h80, 2'h0, 8'h1f, 8'h1c, 21'h0, 1'b1, 1'b0);
    fire(8'h88, 2'h0, 8'h1f, 8'h1c, 21'h0, 1'b1, 1'b0);
    fire(8'h60, 2'h0, 8'h03, 8'h1e, 21'h0, 1'b1, 1'b0);
  endtask

  task automatic t_stack();
    fire(8'h02, 2'h0, 8'h1f, 8'h1f, 21'h100, 1'b0, 1'b0);
    rd(5'h04, 32'h40);
    fire(8'h04, 2'h0, 8'h1f, 8'h1f, 21'h100, 1'b0, 1'b0);
    rd(5'h04, 32'hc0);
    wr(5'h04, 32'h0, 4'hf);
    wr(5'h08, 32'h1, 4'hf);
    fire(8'h04, 2'h0, 8'h1f, 8'h1f, 21'h0, 1'b1, 1'b0);
    rd(5'h04, 32'h80);
    fire(8'h02, 2'h0, 8'h1f, 8'h1f, 21'h0, 1'b1, 1'b0);
    wr(5'h08, 32'h0, 4'hf);
  endtask

  task automatic t_wake();
    wr(5'h14, 32'h00001abc, 4'hf);
    fire(8'h08, 2'h3, 8'h1f, 8'h13, 21'h102, 1'b0, 1'b1);
    rd(5'h14, 32'h1abc);
    fire(8'h01, 2'h2, 8'h1f, 8'h1b, 21'h102, 1'b0, 1'b1);
    fire(8'h01, 2'h0, 8'h1f, 8'h1f, 21'h100, 1'b0, 1'b0);
    hi_en_r <= 1'b1;
    fire(8'h01, 2'h1, 8'h1f, 8'h1b, 21'h008, 1'b0, 1'b1);
    rd(5'h10, 32'h102);
    hi_en_r <= 1'b0;
    lo_en_r <= 1'b1;
    fire(8'h01, 2'h2, 8'h1f, 8'h1b, 21'h018, 1'b0, 1'b1);
    lo_en_r <= 1'b0;
  endtask

  task automatic t_sbor();
    wr(5'h08, 32'h2, 4'hf);
    wr(5'h00, 32'h5f, 4'hf);
    rd(5'h00, 32'h5f);
    rd(5'h08, 32'h2);
    wr(5'h08, 32'h0, 4'hf);
    rd(5'h00, 32'h1f);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_flags();
    t_stack();
    t_wake();
    t_sbor();
    print_verdict();
  end
endmodule
